// ### rtl/stack_seq_pkg.sv
// Constants, register map and state codes for the stack connect sequencer.
// Assumes a single 200 MHz system clock and a 1 ms sequencing tick.
package stack_seq_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Delay bounds in milliseconds
  localparam logic [15:0] PRECHG_MIN_MS = 16'd1000;
  localparam logic [15:0] PRECHG_MAX_MS = 16'd10000;
  localparam logic [15:0] CONNECT_MAX_MS = 16'd10000;
  localparam logic [15:0] DISCONNECT_MAX_MS = 16'd10000;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BIAS_DLY_OFS = 8'h04;
  localparam logic [7:0] PRECHG_DLY_OFS = 8'h08;
  localparam logic [7:0] CONN_DLY_OFS = 8'h0c;
  localparam logic [7:0] DISC_DLY_OFS = 8'h10;
  localparam logic [7:0] PRECHG_MAX_OFS = 8'h14;
  localparam logic [7:0] PRECHG_OC_OFS = 8'h18;
  localparam logic [7:0] MAX_CHG_OFS = 8'h1c;
  localparam logic [7:0] MAX_DIS_OFS = 8'h20;
  localparam logic [7:0] MIN_CHG_OFS = 8'h24;
  localparam logic [7:0] ATTACK_OFS = 8'h28;
  localparam logic [7:0] DECAY_OFS = 8'h2c;
  localparam logic [7:0] STATUS_OFS = 8'h30;
  localparam logic [7:0] BIAS_CUR_OFS = 8'h34;
  localparam logic [7:0] LIMITS_OFS = 8'h38;
  // Control register fields
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_NO_PRECHG_BIT = 1;
  localparam int CTRL_NO_CONNECTING_BIT = 2;
  localparam int CTRL_ROLLOFF_BIT = 3;
  localparam int CTRL_OC_EN_BIT = 4;
  localparam int CTRL_CONN_REQ_BIT = 8;
  localparam int CTRL_DISC_REQ_BIT = 9;
  // Status register fields
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_OC_BIT = 1;
  localparam int STAT_EXT_BIT = 2;
  localparam int STAT_PRE_BIT = 4;
  localparam int STAT_MAIN_BIT = 5;
  localparam int STAT_STATE_LSB = 8;
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [15:0] CUR_RST = 16'h0000;
  // Limit slew shaping
  localparam int SLEW_PERIOD_SHIFT = 4;
  localparam int SLEW_STEP_SHIFT = 3;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_DISCONNECTED = 6'b000001,
    ST_BIAS = 6'b000010,
    ST_PRECHARGE = 6'b000100,
    ST_CONNECTING = 6'b001000,
    ST_CONNECTED = 6'b010000,
    ST_DISCONNECTING = 6'b100000
  } seq_state_e;
endpackage

// ### rtl/stack_connect_sequencer.sv
// Stack connect sequencer: contactor sequencing and charge/discharge current limits.
// Assumes an APB master on pclk, current and scale inputs on pclk, fault and request pins async.
`timescale 1ns/1ps

// Function
// [R1] With auto-connect set, connect on power-up and after faults clear, if fault-free.
// [R2] With auto-connect clear, stay disconnected until an external connect request.
// [R3] Never start or continue a connection while any fault is active.
// [R4] Wait the bias delay before pre-charge, then store stack current as bias.
// [R5] Subtract stored bias from every pre-charge current before fault comparisons.
// [R6] Pre-charge disable set skips pre-charge and goes to the next step.
// [R7] Keep pre-charge energized for its delay, clamped between 1 s and 10 s.
// [R8] Enabled pre-charge over-current aborts pre-charge at once.
// [R9] At pre-charge end, magnitude not below maximum raises the pre-charge timeout fault.
// [R10] After pre-charge, main and pre-charge closed together; pre-charge opens at sequence end.
// [R11] Maximum pre-charge current of zero disables pre-charge entirely.
// [R12] Connecting disable set enters connected state right after pre-charge.
// [R13] Hold both contactors for the connect delay, clamped to at most 10 s.
// [R14] Connecting disable nonzero makes the connect delay zero.
// [R15] Connect delay sits between limit enabling and final contactor closing; the code enables limits only after the delay, on entering connected.
// [R16] Disconnect request zeroes limits, waits the delay (max 10 s), opens contactors.
// [R17] A fault opens the contactors immediately, without the disconnect delay.
// [R18] Maximum charge and discharge settings are positive magnitudes used unthrottled.
// [R19] Charge limit stays at or above minimum charge current until maximum voltage.
// [R20] Limit decreases slew by the attack settling time.
// [R21] Limit increases slew by the decay settling time.
// [R22] Roll-off set gives a non-linear taper, clear gives a linear taper.
// [R23] Limits are zero in every state but connected.
// [R24] Delays count 1 ms ticks; reset leaves the stack disconnected, contactors open.
module stack_connect_sequencer #(
  parameter int unsigned TICK_CYCLES_P = stack_seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements on pclk
  input wire logic [15:0] stack_current,
  input wire logic [7:0] charge_scale,
  input wire logic [7:0] discharge_scale,
  input wire logic at_max_voltage,
  // Asynchronous pins
  input wire logic fault_in,
  input wire logic connect_req_in,
  input wire logic disconnect_req_in,
  // Contactor drives
  output logic precharge_contactor,
  output logic main_contactor,
  output logic stack_contactor,
  // Current limits
  output logic [15:0] charge_limit,
  output logic [15:0] discharge_limit
);
  import stack_seq_pkg::*;

  seq_state_e state_reg, state_next;
  logic [4:0] ctrl_reg;
  logic [15:0] bias_dly_reg, prechg_dly_reg, conn_dly_reg, disc_dly_reg;
  logic [15:0] prechg_max_reg, prechg_oc_reg, max_chg_reg, max_dis_reg, min_chg_reg;
  logic [15:0] attack_reg, decay_reg, bias_cur_reg;
  logic timeout_flt_reg, oc_flt_reg;
  logic [2:0] sync1_reg, sync2_reg, sync3_reg;
  logic [17:0] tick_cnt_reg;
  logic tick_reg;
  logic [15:0] tmr_reg;
  logic auto_armed_reg, fault_prev_reg;
  logic [15:0] lim_reg [2];
  // APB decode
  logic wr_en, rd_en;
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & ~penable & ~pwrite;

  logic sw_conn, sw_disc, sw_clr_to, sw_clr_oc;
  assign sw_conn = wr_en && paddr == CTRL_OFS && pwdata[CTRL_CONN_REQ_BIT];
  assign sw_disc = wr_en && paddr == CTRL_OFS && pwdata[CTRL_DISC_REQ_BIT];
  assign sw_clr_to = wr_en && paddr == STATUS_OFS && pwdata[STAT_TIMEOUT_BIT];
  assign sw_clr_oc = wr_en && paddr == STATUS_OFS && pwdata[STAT_OC_BIT];
  // Pin synchronisers and request edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end else begin
      sync1_reg <= {disconnect_req_in, connect_req_in, fault_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic ext_fault, pin_conn, pin_disc;
  assign ext_fault = sync2_reg[0];
  assign pin_conn = sync2_reg[1] & ~sync3_reg[1];
  assign pin_disc = sync2_reg[2] & ~sync3_reg[2];
  // Millisecond tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 18'h0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 18'(TICK_CYCLES_P - 1)) begin
      tick_cnt_reg <= 18'h0;
      tick_reg <= 1'b1; // [R24]
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 18'h1;
      tick_reg <= 1'b0;
    end
  end
  // Bias-corrected current and magnitudes
  logic signed [16:0] corr;
  logic [16:0] corr_mag;
  assign corr = 17'(signed'(stack_current)) - 17'(signed'(bias_cur_reg)); // [R5]
  assign corr_mag = corr[16] ? 17'(-corr) : corr;
  // Clamped delays
  logic [15:0] prechg_ms, conn_ms, disc_ms;
  always_comb begin
    prechg_ms = prechg_dly_reg;
    if (prechg_dly_reg < PRECHG_MIN_MS) prechg_ms = PRECHG_MIN_MS; // [R7]
    if (prechg_dly_reg > PRECHG_MAX_MS) prechg_ms = PRECHG_MAX_MS; // [R7]
    conn_ms = (conn_dly_reg > CONNECT_MAX_MS) ? CONNECT_MAX_MS : conn_dly_reg; // [R13]
    disc_ms = (disc_dly_reg > DISCONNECT_MAX_MS) ? DISCONNECT_MAX_MS : disc_dly_reg; // [R16]
  end

  logic any_fault, skip_prechg, skip_connecting, conn_req, disc_req;
  logic oc_trip, prechg_end, prechg_bad;
  assign any_fault = ext_fault | timeout_flt_reg | oc_flt_reg;
  assign skip_prechg = ctrl_reg[CTRL_NO_PRECHG_BIT] | (prechg_max_reg == 16'h0); // [R6] [R11]
  assign skip_connecting = ctrl_reg[CTRL_NO_CONNECTING_BIT]; // [R14]
  assign conn_req = sw_conn | pin_conn | (ctrl_reg[CTRL_AUTO_BIT] & auto_armed_reg);
  assign disc_req = sw_disc | pin_disc;
  assign oc_trip = state_reg == ST_PRECHARGE && ctrl_reg[CTRL_OC_EN_BIT]
    && corr_mag > {1'b0, prechg_oc_reg}; // [R8]
  assign prechg_end = state_reg == ST_PRECHARGE && tmr_reg >= prechg_ms;
  assign prechg_bad = corr_mag >= {1'b0, prechg_max_reg}; // [R9]
  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DISCONNECTED: begin
        if (conn_req && !any_fault) state_next = ST_BIAS; // [R1] [R2]
      end
      ST_BIAS: begin
        if (tmr_reg >= bias_dly_reg) begin
          if (!skip_prechg) state_next = ST_PRECHARGE;
          else if (skip_connecting) state_next = ST_CONNECTED; // [R6] [R12]
          else state_next = ST_CONNECTING;
        end
      end
      ST_PRECHARGE: begin
        if (oc_trip) state_next = ST_DISCONNECTED; // [R8]
        else if (prechg_end) begin
          if (prechg_bad) state_next = ST_DISCONNECTED; // [R9]
          else if (skip_connecting) state_next = ST_CONNECTED; // [R12]
          else state_next = ST_CONNECTING; // [R10]
        end
      end
      ST_CONNECTING: begin
        if (tmr_reg >= conn_ms) state_next = ST_CONNECTED; // [R13] [R15]
      end
      ST_CONNECTED: begin
        if (disc_req) state_next = ST_DISCONNECTING; // [R16]
      end
      ST_DISCONNECTING: begin
        if (tmr_reg >= disc_ms) state_next = ST_DISCONNECTED; // [R16]
      end
      default: state_next = ST_DISCONNECTED;
    endcase
    if (state_reg != ST_CONNECTED && state_reg != ST_DISCONNECTING && disc_req) begin
      state_next = ST_DISCONNECTED;
    end
    if (any_fault) state_next = ST_DISCONNECTED; // [R3] [R17]
  end
  // State and delay timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_DISCONNECTED; // [R24]
      tmr_reg <= 16'h0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) tmr_reg <= 16'h0;
      else if (tick_reg && tmr_reg != 16'hffff) tmr_reg <= tmr_reg + 16'h1; // [R24]
    end
  end
  // Auto-connect arming at power-up and on fault release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_armed_reg <= 1'b1;
      fault_prev_reg <= 1'b0;
    end else begin
      fault_prev_reg <= any_fault;
      if (fault_prev_reg && !any_fault) auto_armed_reg <= 1'b1; // [R1]
      else if (state_reg == ST_BIAS) auto_armed_reg <= 1'b0;
    end
  end
  // Bias capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bias_cur_reg <= CUR_RST;
    else if (state_reg == ST_BIAS && state_next != ST_BIAS && !any_fault) begin
      bias_cur_reg <= stack_current; // [R4]
    end
  end
  // Pre-charge faults, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flt_reg <= 1'b0;
      oc_flt_reg <= 1'b0;
    end else begin
      if (prechg_end && !oc_trip && prechg_bad) timeout_flt_reg <= 1'b1; // [R9]
      else if (sw_clr_to) timeout_flt_reg <= 1'b0;
      if (oc_trip) oc_flt_reg <= 1'b1; // [R8]
      else if (sw_clr_oc) oc_flt_reg <= 1'b0;
    end
  end
  // Contactor drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      precharge_contactor <= 1'b0; // [R24]
      main_contactor <= 1'b0;
      stack_contactor <= 1'b0;
    end else begin
      precharge_contactor <= state_next == ST_PRECHARGE
        || state_next == ST_CONNECTING; // [R10]
      main_contactor <= state_next == ST_CONNECTING || state_next == ST_CONNECTED
        || state_next == ST_DISCONNECTING; // [R10] [R17]
      stack_contactor <= state_next == ST_PRECHARGE || state_next == ST_CONNECTING
        || state_next == ST_CONNECTED || state_next == ST_DISCONNECTING;
    end
  end
  // Taper and targets
  logic [8:0] taper [2];
  logic [15:0] tgt [2];
  logic [15:0] lim_max [2];
  logic [7:0] scale [2];
  assign lim_max[0] = max_chg_reg; // [R18]
  assign lim_max[1] = max_dis_reg; // [R18]
  assign scale[0] = charge_scale;
  assign scale[1] = discharge_scale;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lim
      logic [15:0] sq;
      logic [24:0] prod;
      logic [15:0] raw;
      logic [15:0] sc_reg;
      logic [15:0] period, diff, step;
      logic dn;
      assign sq = 16'(scale[gi]) * 16'(scale[gi]);
      assign taper[gi] = ctrl_reg[CTRL_ROLLOFF_BIT]
        ? 9'({scale[gi], 1'b0} - {1'b0, sq[15:8]}) : {1'b0, scale[gi]}; // [R22]
      assign prod = 25'(lim_max[gi]) * 25'(taper[gi]);
      assign raw = prod[23:8];
      if (gi == 0) begin : g_chg
        assign tgt[gi] = (!at_max_voltage && raw < min_chg_reg) ? min_chg_reg : raw; // [R19]
      end else begin : g_dis
        assign tgt[gi] = raw;
      end
      assign dn = lim_reg[gi] > tgt[gi];
      assign diff = dn ? lim_reg[gi] - tgt[gi] : tgt[gi] - lim_reg[gi];
      assign period = (dn ? attack_reg : decay_reg) >> SLEW_PERIOD_SHIFT; // [R20] [R21]
      assign step = (diff >> SLEW_STEP_SHIFT) + 16'h1;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lim_reg[gi] <= 16'h0;
          sc_reg <= 16'h0;
        end else if (state_next != ST_CONNECTED) begin
          lim_reg[gi] <= 16'h0; // [R23] [R16]
          sc_reg <= 16'h0;
        end else if (tick_reg) begin
          if (sc_reg + 16'h1 >= period) begin
            sc_reg <= 16'h0;
            if (dn) lim_reg[gi] <= lim_reg[gi] - ((step > diff) ? diff : step); // [R20]
            else lim_reg[gi] <= lim_reg[gi] + ((step > diff) ? diff : step); // [R21]
          end else begin
            sc_reg <= sc_reg + 16'h1;
          end
        end
      end
    end
  endgenerate

  assign charge_limit = lim_reg[0];
  assign discharge_limit = lim_reg[1];
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      bias_dly_reg <= DLY_RST;
      prechg_dly_reg <= DLY_RST;
      conn_dly_reg <= DLY_RST;
      disc_dly_reg <= DLY_RST;
      prechg_max_reg <= CUR_RST;
      prechg_oc_reg <= CUR_RST;
      max_chg_reg <= CUR_RST;
      max_dis_reg <= CUR_RST;
      min_chg_reg <= CUR_RST;
      attack_reg <= DLY_RST;
      decay_reg <= DLY_RST;
    end else if (wr_en) begin
      case (paddr)
        CTRL_OFS: ctrl_reg <= pwdata[4:0];
        BIAS_DLY_OFS: bias_dly_reg <= pwdata[15:0];
        PRECHG_DLY_OFS: prechg_dly_reg <= pwdata[15:0];
        CONN_DLY_OFS: conn_dly_reg <= pwdata[15:0];
        DISC_DLY_OFS: disc_dly_reg <= pwdata[15:0];
        PRECHG_MAX_OFS: prechg_max_reg <= pwdata[15:0];
        PRECHG_OC_OFS: prechg_oc_reg <= pwdata[15:0];
        MAX_CHG_OFS: max_chg_reg <= pwdata[15:0];
        MAX_DIS_OFS: max_dis_reg <= pwdata[15:0];
        MIN_CHG_OFS: min_chg_reg <= pwdata[15:0];
        ATTACK_OFS: attack_reg <= pwdata[15:0];
        DECAY_OFS: decay_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read mux
  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      CTRL_OFS: rd_val = {27'h0, ctrl_reg};
      BIAS_DLY_OFS: rd_val = {16'h0, bias_dly_reg};
      PRECHG_DLY_OFS: rd_val = {16'h0, prechg_dly_reg};
      CONN_DLY_OFS: rd_val = {16'h0, conn_dly_reg};
      DISC_DLY_OFS: rd_val = {16'h0, disc_dly_reg};
      PRECHG_MAX_OFS: rd_val = {16'h0, prechg_max_reg};
      PRECHG_OC_OFS: rd_val = {16'h0, prechg_oc_reg};
      MAX_CHG_OFS: rd_val = {16'h0, max_chg_reg};
      MAX_DIS_OFS: rd_val = {16'h0, max_dis_reg};
      MIN_CHG_OFS: rd_val = {16'h0, min_chg_reg};
      ATTACK_OFS: rd_val = {16'h0, attack_reg};
      DECAY_OFS: rd_val = {16'h0, decay_reg};
      STATUS_OFS: begin
        rd_val[STAT_TIMEOUT_BIT] = timeout_flt_reg;
        rd_val[STAT_OC_BIT] = oc_flt_reg;
        rd_val[STAT_EXT_BIT] = ext_fault;
        rd_val[STAT_PRE_BIT] = precharge_contactor;
        rd_val[STAT_MAIN_BIT] = main_contactor;
        rd_val[STAT_STATE_LSB +: 6] = state_reg;
      end
      BIAS_CUR_OFS: rd_val = {16'h0, bias_cur_reg};
      LIMITS_OFS: rd_val = {discharge_limit, charge_limit};
      default: rd_hit = 1'b0;
    endcase
  end

  // APB answer: no wait states, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (rd_en) prdata <= rd_val;
    end
  end
endmodule

// ### dv/stack_seq_chk.sv
// Port checker for the stack connect sequencer.
// Assumes one domain on pclk with presetn as its reset; bound to the top.
`timescale 1ns/1ps
module stack_seq_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and outputs
  input wire logic fault_in,
  input wire logic precharge_contactor,
  input wire logic main_contactor,
  input wire logic stack_contactor,
  input wire logic [15:0] charge_limit,
  input wire logic [15:0] discharge_limit
);
  import stack_seq_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_disc_wr;
    psel && penable && pready && pwrite && paddr == CTRL_OFS && pwdata[CTRL_DISC_REQ_BIT];
  endsequence
  sequence s_lims_zero;
    charge_limit == 16'h0000 && discharge_limit == 16'h0000;
  endsequence
  sequence s_lims_nz;
    charge_limit != 16'h0000 || discharge_limit != 16'h0000;
  endsequence
  property p_ready_wait;
    s_setup |=> pready;
  endproperty
  property p_ready_access;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_stack_or;
    stack_contactor == (precharge_contactor || main_contactor);
  endproperty
  property p_fault_open;
    fault_in [*6] |-> !precharge_contactor && !main_contactor && !stack_contactor;
  endproperty
  property p_fault_lims;
    fault_in [*6] |-> s_lims_zero;
  endproperty
  property p_reset_open;
    $rose(presetn) |-> !precharge_contactor && !main_contactor ##0 s_lims_zero;
  endproperty
  property p_lims_conn;
    s_lims_nz [*3] |-> main_contactor && stack_contactor && !precharge_contactor;
  endproperty
  property p_disc_zero;
    s_disc_wr |-> ##[1:3] s_lims_zero;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_stack_or: assert property (p_stack_or) else $error("stack contactor mismatch");
  a_fault_open: assert property (p_fault_open) else $error("fault left contactor");
  a_fault_lims: assert property (p_fault_lims) else $error("limits under fault");
  a_reset_open: assert property (p_reset_open) else $error("not open at reset");
  a_lims_conn: assert property (p_lims_conn) else $error("limits off connected");
  a_disc_zero: assert property (p_disc_zero) else $error("limits kept on disc");
endmodule

bind stack_connect_sequencer stack_seq_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .fault_in, .precharge_contactor, .main_contactor,
  .stack_contactor, .charge_limit, .discharge_limit);

// ### dv/stack_load_model.sv
// Far side model: contactor bank with sensor offset, inrush and charger draw.
// Assumes pclk domain; current levels come from the testbench.
`timescale 1ns/1ps
module stack_load_model (
  // Clock
  input wire logic pclk,
  // Contactor drives
  input wire logic precharge_contactor,
  input wire logic main_contactor,
  input wire logic stack_contactor,
  // Current levels
  input wire logic [15:0] idle_cur,
  input wire logic [15:0] inrush_cur,
  input wire logic [15:0] charge_limit,
  // Measured current and pre-charge closures
  output logic [15:0] stack_current,
  output logic [15:0] pre_count
);
  logic pre_d;
  initial begin
    stack_current = 16'h0000;
    pre_count = 16'h0000;
    pre_d = 1'b0;
  end
  // Open path shows only the sensor offset
  always @(posedge pclk) begin
    pre_d <= precharge_contactor;
    if (precharge_contactor && !pre_d) begin
      pre_count <= pre_count + 16'h0001;
    end
    if (!stack_contactor) begin
      stack_current <= idle_cur;
    end else if (main_contactor) begin
      stack_current <= charge_limit;
    end else begin
      stack_current <= inrush_cur;
    end
  end
endmodule

// ### dv/stack_connect_sequencer_tb_top.sv
// Self-checking bench for the stack connect sequencer.
// Assumes a 10-cycle millisecond tick and the load model on the far side.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module stack_connect_sequencer_tb_top;
  import stack_seq_pkg::*;
  localparam int T = 10;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, charge_scale = 8'hff, discharge_scale = 8'hff;
  logic [31:0] pwdata = 0, prdata, r, wd;
  logic pready, pslverr, at_max_voltage = 0, fault_in = 0;
  logic connect_req_in = 0, disconnect_req_in = 0, e;
  logic precharge_contactor, main_contactor, stack_contactor;
  logic [15:0] stack_current, charge_limit, discharge_limit, pre_count, cnt0;
  logic [15:0] idle_cur, inrush_cur = 0;
  int err_count = 0, tests_run = 0, seed = 10, c;
  stack_connect_sequencer #(.TICK_CYCLES_P(T)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stack_current, .charge_scale,
    .discharge_scale, .at_max_voltage, .fault_in, .connect_req_in, .disconnect_req_in,
    .precharge_contactor, .main_contactor, .stack_contactor, .charge_limit, .discharge_limit);
  stack_load_model i_load (.pclk, .precharge_contactor, .main_contactor, .stack_contactor,
    .idle_cur, .inrush_cur, .charge_limit, .stack_current, .pre_count);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  function automatic int tgt(int mx, int s, int roll);
    int t;
    t = roll ? 2 * s - s * s / 256 : s;
    return mx * t / 256;
  endfunction
  function automatic logic sig(int s);
    return s == 0 ? precharge_contactor : main_contactor;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    `CHK(n < 50, 1'b1)
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input int s, input logic v);
    c = 0;
    while (sig(s) !== v && c < 20000) begin
      @(posedge pclk);
      c++;
    end
    `CHK(c < 20000, 1'b1)
  endtask
  task automatic near(input int ms);
    `CHK(c >= (ms - 1) * T && c <= ms * T + T + 4, 1'b1)
  endtask
  task automatic pulse(input logic dis);
    @(posedge pclk);
    if (dis) disconnect_req_in <= 1'b1;
    else connect_req_in <= 1'b1;
    repeat (4) @(posedge pclk);
    connect_req_in <= 1'b0;
    disconnect_req_in <= 1'b0;
  endtask
  task automatic cfg(input int v[11]);
    for (int i = 0; i < 11; i++) apb(1'b1, 8'(4 + 4 * i), 32'(v[i]));
  endtask
  task automatic conclude();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    conclude();
  end
  initial begin
    idle_cur = 16'(64 + ($random(seed) & 63));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    for (int a = 0; a <= 'h38; a += 4) begin
      apb(1'b0, 8'(a), 0);
      `CHK(r, (8'(a) == STATUS_OFS) ? 32'h100 : 32'h0)
    end
    apb(1'b0, 8'h3c, 0);
    `CHK({e, r}, 33'h100000000)
    for (int a = 4; a <= 'h2c; a += 4) begin
      wd = $random(seed);
      apb(1'b1, 8'(a), wd);
      apb(1'b0, 8'(a), 0);
      `CHK(r, {16'h0, wd[15:0]})
    end
    cfg('{2, 5, 3, 4, 100, 500, 1000, 800, 0, 0, 0});
    apb(1'b1, CTRL_OFS, 0);
    inrush_cur <= idle_cur + 16'd40;
    pulse(1'b0);
    wt(0, 1'b1);
    apb(1'b0, BIAS_CUR_OFS, 0);
    `CHK(r[15:0], idle_cur)
    wt(1, 1'b1);
    near(1000);
    wt(0, 1'b0);
    near(3);
    repeat (1500) @(posedge pclk);
    `CHK(charge_limit, 16'(tgt(1000, 255, 0)))
    apb(1'b0, LIMITS_OFS, 0);
    `CHK(r, {16'(tgt(800, 255, 0)), 16'(tgt(1000, 255, 0))})
    discharge_scale <= 8'd128;
    repeat (1500) @(posedge pclk);
    `CHK(discharge_limit, 16'(tgt(800, 128, 0)))
    apb(1'b1, CTRL_OFS, 32'h8);
    repeat (1500) @(posedge pclk);
    `CHK(discharge_limit, 16'(tgt(800, 128, 1)))
    apb(1'b1, MIN_CHG_OFS, 900);
    charge_scale <= 8'd0;
    repeat (1500) @(posedge pclk);
    `CHK(charge_limit, 16'd900)
    at_max_voltage <= 1'b1;
    repeat (1500) @(posedge pclk);
    `CHK(charge_limit, 16'd0)
    apb(1'b1, CTRL_OFS, 32'h200);
    repeat (3) @(posedge pclk);
    `CHK({charge_limit, discharge_limit}, 32'h0)
    wt(1, 1'b0);
    near(4);
    apb(1'b1, CTRL_OFS, 32'h10);
    inrush_cur <= idle_cur + 16'd600;
    pulse(1'b0);
    wt(0, 1'b1);
    wt(0, 1'b0);
    `CHK(c <= 6 && main_contactor === 1'b0, 1'b1)
    apb(1'b0, STATUS_OFS, 0);
    `CHK(r[STAT_OC_BIT], 1'b1)
    apb(1'b1, CTRL_OFS, 32'h110);
    repeat (50) @(posedge pclk);
    `CHK(stack_contactor, 1'b0)
    apb(1'b1, STATUS_OFS, 32'h3);
    apb(1'b1, CTRL_OFS, 32'h0);
    inrush_cur <= idle_cur + 16'd100;
    pulse(1'b0);
    wt(0, 1'b1);
    wt(0, 1'b0);
    near(1000);
    apb(1'b0, STATUS_OFS, 0);
    `CHK({r[STAT_TIMEOUT_BIT], main_contactor}, 2'b10)
    apb(1'b1, STATUS_OFS, 32'h3);
    cnt0 = pre_count;
    apb(1'b1, CTRL_OFS, 32'h7);
    wt(1, 1'b1);
    near(2);
    `CHK(pre_count, cnt0)
    @(posedge pclk);
    fault_in <= 1'b1;
    wt(1, 1'b0);
    `CHK(c <= 6, 1'b1)
    apb(1'b1, PRECHG_MAX_OFS, 0);
    apb(1'b1, CTRL_OFS, 32'h5);
    fault_in <= 1'b0;
    wt(1, 1'b1);
    `CHK(c <= 3 * T + 6 && pre_count === cnt0, 1'b1)
    pulse(1'b1);
    wt(1, 1'b0);
    near(4);
    conclude();
  end
endmodule
